// File: design/trap_ctrl_pkg.sv
// Package with register map, field positions and carriers for trap control registers
`default_nettype none
package trap_ctrl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    // Register word offsets
    localparam logic [3:0] CORE_MODE_CONTROL_OFF = 4'h0;
    localparam logic [3:0] TRAP_FLAGS_AND_NESTING_OFF = 4'h1;
    localparam logic [3:0] GLOBAL_IRQ_AND_EDGE_CTRL_OFF = 4'h2;
    localparam logic [3:0] SOFT_TRAP_STATUS_OFF = 4'h3;
    localparam logic [3:0] STATUS_PRIORITY_OFF = 4'h4;
    // Core mode control fields
    localparam int VAR_LATENCY_BIT = 15;
    localparam int PRIORITY_EXT_BIT = 3;
    // Trap flags and nesting fields
    localparam int NESTING_DISABLE_BIT = 15;
    localparam int ACC_A_OVF_BIT = 14;
    localparam int ACC_B_OVF_BIT = 13;
    localparam int ACC_A_CAT_BIT = 12;
    localparam int ACC_B_CAT_BIT = 11;
    localparam int ACC_A_OVF_EN_BIT = 10;
    localparam int ACC_B_OVF_EN_BIT = 9;
    localparam int CAT_EN_BIT = 8;
    localparam int BAD_SHIFT_BIT = 7;
    localparam int DIV_ZERO_BIT = 6;
    localparam int DMA_TRAP_BIT = 5;
    localparam int MATH_TRAP_BIT = 4;
    localparam int ADDR_TRAP_BIT = 3;
    localparam int STACK_TRAP_BIT = 2;
    localparam int OSC_FAIL_BIT = 1;
    // Global irq and edge control fields
    localparam int GLOBAL_EN_BIT = 15;
    localparam int TIMED_DIS_BIT = 14;
    localparam int SW_TRAP_BIT = 13;
    localparam int ALT_VECTOR_BIT = 8;
    localparam int EXT_IRQ_COUNT = 4;
    // Soft trap status fields
    localparam int CAN_ADDR_BIT = 9;
    localparam int NVM_ADDR_BIT = 8;
    localparam int LOOP_OVF_BIT = 4;
    localparam int AUX_PLL_UNLOCK_SOFT_TRAP_BIT = 0;
    // Status priority register field (low priority bits)
    localparam int PRIO_LOW_LSB = 5;
    // Implemented-bit masks; all else reads zero
    localparam logic [15:0] CORE_MODE_MASK = 16'h8008;
    localparam logic [15:0] TRAP_FLAGS_MASK = 16'hfffe;
    localparam logic [15:0] GLOBAL_CTRL_MASK = 16'he10f;
    localparam logic [15:0] SOFT_TRAP_MASK = 16'h0311;
    localparam logic [15:0] STATUS_PRIO_MASK = 16'h00e0;
    // Reset value and highest low priority level
    localparam logic [15:0] GLOBAL_CTRL_RESET = 16'h8000;
    localparam logic [2:0] PRIO_MAX_LOW = 3'h7;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic write;
        logic read;
    } reg_req_s;

    // Trap events from core and peripherals, one-cycle pulses
    typedef struct packed {
        logic acc_a_overflow;
        logic acc_b_overflow;
        logic acc_a_catastrophic;
        logic acc_b_catastrophic;
        logic bad_shift;
        logic divide_zero;
        logic dma_error;
        logic address_error;
        logic stack_error;
        logic osc_failure;
        logic can_address;
        logic nvm_address;
        logic loop_stack_overflow;
        logic aux_pll_unlock;
    } trap_events_s;

    // Controls presented to the core
    typedef struct packed {
        logic variable_latency;
        logic nesting_disabled;
        logic user_irq_allowed;
        logic alt_vector_table;
        logic software_trap;
        logic [3:0] priority_level;
    } core_ctrl_s;
endpackage : trap_ctrl_pkg
`default_nettype wire

// File: design/trap_ctrl_regs.sv
// Trap and interrupt control and status registers with external edge detection
`default_nettype none
module trap_ctrl_regs (
    input wire logic clock,
    input wire logic reset,
    input wire trap_ctrl_pkg::reg_req_s reg_req,
    output logic [15:0] reg_rdata,
    input wire trap_ctrl_pkg::trap_events_s trap_events,
    input wire logic timed_irq_disable_in,
    input wire logic priority_raise,
    input wire logic [3:0] priority_raise_level,
    input wire logic [3:0] ext_irq_pin,
    output logic [3:0] ext_irq_edge,
    output trap_ctrl_pkg::core_ctrl_s core_ctrl,
    output logic math_trap,
    output logic acc_overflow_trap
);
    import trap_ctrl_pkg::*;

    logic variable_latency_reg;
    logic priority_level_ext_reg;
    logic [2:0] priority_level_low_reg;
    logic [15:0] trap_flags_reg;
    logic [15:0] global_ctrl_reg;
    logic [15:0] soft_trap_reg;
    logic [15:0] trap_set;
    logic [15:0] soft_set;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;
    logic [3:0] level_reg;
    logic [3:0] ext_irq_edge_reg;
    logic [15:0] reg_rdata_reg;
    logic wr_core;
    logic wr_trap;
    logic wr_global;
    logic wr_soft;
    logic wr_prio;
    logic acc_a_fire;
    logic acc_b_fire;
    logic cat_a_fire;
    logic cat_b_fire;
    logic math_fire;

    // Write decodes
    assign wr_core = reg_req.write && reg_req.addr == CORE_MODE_CONTROL_OFF;
    assign wr_trap = reg_req.write && reg_req.addr == TRAP_FLAGS_AND_NESTING_OFF;
    assign wr_global = reg_req.write && reg_req.addr == GLOBAL_IRQ_AND_EDGE_CTRL_OFF;
    assign wr_soft = reg_req.write && reg_req.addr == SOFT_TRAP_STATUS_OFF;
    assign wr_prio = reg_req.write && reg_req.addr == STATUS_PRIORITY_OFF;

    // Overflow events only become traps when their enables allow it
    assign acc_a_fire = trap_events.acc_a_overflow && trap_flags_reg[ACC_A_OVF_EN_BIT];
    assign acc_b_fire = trap_events.acc_b_overflow && trap_flags_reg[ACC_B_OVF_EN_BIT];
    assign cat_a_fire = trap_events.acc_a_catastrophic && trap_flags_reg[CAT_EN_BIT];
    assign cat_b_fire = trap_events.acc_b_catastrophic && trap_flags_reg[CAT_EN_BIT];
    assign math_fire = acc_a_fire || acc_b_fire || cat_a_fire || cat_b_fire
        || trap_events.bad_shift || trap_events.divide_zero;

    // Hard trap set vector, aligned with register bits
    always_comb begin
        trap_set = 16'h0000;
        trap_set[ACC_A_OVF_BIT] = acc_a_fire;
        trap_set[ACC_B_OVF_BIT] = acc_b_fire;
        trap_set[ACC_A_CAT_BIT] = cat_a_fire;
        trap_set[ACC_B_CAT_BIT] = cat_b_fire;
        trap_set[BAD_SHIFT_BIT] = trap_events.bad_shift;
        trap_set[DIV_ZERO_BIT] = trap_events.divide_zero;
        trap_set[DMA_TRAP_BIT] = trap_events.dma_error;
        trap_set[MATH_TRAP_BIT] = math_fire;
        trap_set[ADDR_TRAP_BIT] = trap_events.address_error;
        trap_set[STACK_TRAP_BIT] = trap_events.stack_error;
        trap_set[OSC_FAIL_BIT] = trap_events.osc_failure;
    end

    // Soft trap set vector
    always_comb begin
        soft_set = 16'h0000;
        soft_set[CAN_ADDR_BIT] = trap_events.can_address;
        soft_set[NVM_ADDR_BIT] = trap_events.nvm_address;
        soft_set[LOOP_OVF_BIT] = trap_events.loop_stack_overflow;
        soft_set[AUX_PLL_UNLOCK_SOFT_TRAP_BIT] = trap_events.aux_pll_unlock;
    end

    // Trap flags and nesting; a set in the write cycle survives the write
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            trap_flags_reg <= 16'h0000;
        end else if (wr_trap) begin
            trap_flags_reg <= (reg_req.wdata & TRAP_FLAGS_MASK) | trap_set;
        end else begin
            trap_flags_reg <= trap_flags_reg | trap_set;
        end
    end

    // Soft trap status with the same set-wins policy
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            soft_trap_reg <= 16'h0000;
        end else if (wr_soft) begin
            soft_trap_reg <= (reg_req.wdata & SOFT_TRAP_MASK) | soft_set;
        end else begin
            soft_trap_reg <= soft_trap_reg | soft_set;
        end
    end

    // Global control; the timed disable bit mirrors the core, not software
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            global_ctrl_reg <= GLOBAL_CTRL_RESET;
        end else begin
            if (wr_global) begin
                global_ctrl_reg <= reg_req.wdata & GLOBAL_CTRL_MASK;
            end
            global_ctrl_reg[TIMED_DIS_BIT] <= timed_irq_disable_in;
        end
    end

    // Latency mode control bit
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            variable_latency_reg <= 1'b0;
        end else if (wr_core) begin
            variable_latency_reg <= reg_req.wdata[VAR_LATENCY_BIT];
        end
    end

    // Priority level; hardware raise from the core wins over a software write
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            priority_level_ext_reg <= 1'b0;
            priority_level_low_reg <= 3'h0;
        end else if (priority_raise) begin
            priority_level_ext_reg <= priority_raise_level[3];
            priority_level_low_reg <= priority_raise_level[2:0];
        end else begin
            // Extension is clear-only: writing zero clears, writing one does nothing
            if (wr_core && !reg_req.wdata[PRIORITY_EXT_BIT]) begin
                priority_level_ext_reg <= 1'b0;
            end
            if (wr_prio && !trap_flags_reg[NESTING_DISABLE_BIT]) begin
                priority_level_low_reg <= reg_req.wdata[PRIO_LOW_LSB +: 3];
            end
        end
    end

    // Three-stage synchroniser; a change counts when stages two and three agree
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            sync3_reg <= 4'h0;
        end else begin
            sync1_reg <= ext_irq_pin;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Edge detect per input with its own polarity
    genvar gi;
    generate
        for (gi = 0; gi < EXT_IRQ_COUNT; gi++) begin : g_edge
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    level_reg[gi] <= 1'b0;
                    ext_irq_edge_reg[gi] <= 1'b0;
                end else if (sync2_reg[gi] == sync3_reg[gi]) begin
                    // Only an agreed level moves state; a one-cycle glitch never does
                    level_reg[gi] <= sync3_reg[gi];
                    ext_irq_edge_reg[gi] <= (sync3_reg[gi] != level_reg[gi])
                        && (sync3_reg[gi] != global_ctrl_reg[gi]);
                end else begin
                    ext_irq_edge_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Read mux, registered so data stands the cycle after the strobe
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reg_rdata_reg <= 16'h0000;
        end else if (reg_req.read) begin
            unique case (reg_req.addr)
                CORE_MODE_CONTROL_OFF: begin
                    reg_rdata_reg <= {variable_latency_reg, 11'h000,
                        priority_level_ext_reg, 3'h0};
                end
                TRAP_FLAGS_AND_NESTING_OFF: begin
                    reg_rdata_reg <= trap_flags_reg & TRAP_FLAGS_MASK;
                end
                GLOBAL_IRQ_AND_EDGE_CTRL_OFF: begin
                    reg_rdata_reg <= global_ctrl_reg & GLOBAL_CTRL_MASK;
                end
                SOFT_TRAP_STATUS_OFF: begin
                    reg_rdata_reg <= soft_trap_reg & SOFT_TRAP_MASK;
                end
                STATUS_PRIORITY_OFF: begin
                    reg_rdata_reg <= {8'h00, priority_level_low_reg, 5'h00};
                end
                default: begin
                    reg_rdata_reg <= 16'h0000; // Unmapped reads zero
                end
            endcase
        end else begin
            reg_rdata_reg <= 16'h0000;
        end
    end

    // Outputs toward the core
    assign reg_rdata = reg_rdata_reg;
    assign ext_irq_edge = ext_irq_edge_reg;
    assign math_trap = math_fire;
    assign acc_overflow_trap = acc_a_fire || acc_b_fire || cat_a_fire || cat_b_fire;
    assign core_ctrl.variable_latency = variable_latency_reg;
    assign core_ctrl.nesting_disabled = trap_flags_reg[NESTING_DISABLE_BIT];
    // Traps bypass this gate; only user interrupts are held off
    assign core_ctrl.user_irq_allowed = global_ctrl_reg[GLOBAL_EN_BIT]
        && !priority_level_ext_reg && !global_ctrl_reg[TIMED_DIS_BIT];
    assign core_ctrl.alt_vector_table = global_ctrl_reg[ALT_VECTOR_BIT];
    assign core_ctrl.software_trap = global_ctrl_reg[SW_TRAP_BIT];
    assign core_ctrl.priority_level = {priority_level_ext_reg, priority_level_low_reg};

    // Assertions
    property p_ext_above_seven;
        @(posedge clock) disable iff (reset)
        priority_raise |=> priority_level_ext_reg == ($past(priority_raise_level) > 4'(PRIO_MAX_LOW));
    endproperty
    a_ext_above_seven: assert property (p_ext_above_seven) else $error("ext bit wrong");

    property p_user_block;
        @(posedge clock) disable iff (reset)
        priority_level_ext_reg |-> !core_ctrl.user_irq_allowed;
    endproperty
    a_user_block: assert property (p_user_block) else $error("user irq with ext");

    property p_gie_block;
        @(posedge clock) disable iff (reset)
        !global_ctrl_reg[GLOBAL_EN_BIT] |-> !core_ctrl.user_irq_allowed;
    endproperty
    a_gie_block: assert property (p_gie_block) else $error("irq while disabled");

    property p_ovf_a_gated;
        @(posedge clock) disable iff (reset)
        trap_events.acc_a_overflow && !trap_flags_reg[ACC_A_OVF_EN_BIT]
            && !trap_flags_reg[ACC_A_OVF_BIT] && !wr_trap |=> !trap_flags_reg[ACC_A_OVF_BIT];
    endproperty
    a_ovf_a_gated: assert property (p_ovf_a_gated) else $error("A flag without enable");

    property p_math_set;
        @(posedge clock) disable iff (reset)
        (trap_events.divide_zero || trap_events.bad_shift)
            |=> trap_flags_reg[MATH_TRAP_BIT];
    endproperty
    a_math_set: assert property (p_math_set) else $error("math flag missed");

    property p_set_wins;
        @(posedge clock) disable iff (reset)
        wr_trap && trap_events.stack_error |=> trap_flags_reg[STACK_TRAP_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

    property p_soft_hold;
        @(posedge clock) disable iff (reset)
        trap_events.aux_pll_unlock ##1 !wr_soft[*2] |-> soft_trap_reg[AUX_PLL_UNLOCK_SOFT_TRAP_BIT];
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("pll flag not held");

    property p_prio_locked;
        @(posedge clock) disable iff (reset)
        wr_prio && trap_flags_reg[NESTING_DISABLE_BIT] && !priority_raise
            |=> $stable(priority_level_low_reg);
    endproperty
    a_prio_locked: assert property (p_prio_locked) else $error("prio written");

    sequence s_rise_seen;
        sync2_reg[0] && sync3_reg[0] && !level_reg[0] && !global_ctrl_reg[0];
    endsequence
    property p_rise_edge;
        @(posedge clock) disable iff (reset)
        s_rise_seen |=> ext_irq_edge_reg[0] ##1 !ext_irq_edge_reg[0];
    endproperty
    a_rise_edge: assert property (p_rise_edge) else $error("edge pulse wrong");

    property p_unimpl_zero;
        @(posedge clock) disable iff (reset)
        reg_req.read && reg_req.addr == SOFT_TRAP_STATUS_OFF
            |=> (reg_rdata & ~SOFT_TRAP_MASK) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("reserved bits set");

    // Latency and nesting bits take the written value one cycle later
    property p_latency_follow;
        @(posedge clock) disable iff (reset)
        wr_core |=> core_ctrl.variable_latency == $past(reg_req.wdata[VAR_LATENCY_BIT]);
    endproperty
    a_latency_follow: assert property (p_latency_follow) else $error("latency wrong");

    property p_nest_follow;
        @(posedge clock) disable iff (reset)
        wr_trap |=> core_ctrl.nesting_disabled == $past(reg_req.wdata[NESTING_DISABLE_BIT]);
    endproperty
    a_nest_follow: assert property (p_nest_follow) else $error("nesting wrong");

    // Software can never set the extension bit; only the core raise can
    property p_ext_no_sw_set;
        @(posedge clock) disable iff (reset)
        !priority_raise |=> !$rose(priority_level_ext_reg);
    endproperty
    a_ext_no_sw_set: assert property (p_ext_no_sw_set) else $error("ext bit set by write");

    property p_ovf_b_set;
        @(posedge clock) disable iff (reset)
        trap_events.acc_b_overflow && trap_flags_reg[ACC_B_OVF_EN_BIT]
            |=> trap_flags_reg[ACC_B_OVF_BIT];
    endproperty
    a_ovf_b_set: assert property (p_ovf_b_set) else $error("B flag missed");

    property p_cat_a_set;
        @(posedge clock) disable iff (reset)
        trap_events.acc_a_catastrophic && trap_flags_reg[CAT_EN_BIT]
            |=> trap_flags_reg[ACC_A_CAT_BIT];
    endproperty
    a_cat_a_set: assert property (p_cat_a_set) else $error("A catastrophic missed");

    // A disabled catastrophic event must not leave a flag behind
    property p_cat_b_gated;
        @(posedge clock) disable iff (reset)
        trap_events.acc_b_catastrophic && !trap_flags_reg[CAT_EN_BIT]
            && !trap_flags_reg[ACC_B_CAT_BIT] && !wr_trap |=> !trap_flags_reg[ACC_B_CAT_BIT];
    endproperty
    a_cat_b_gated: assert property (p_cat_b_gated) else $error("B catastrophic ungated");

    property p_shift_set;
        @(posedge clock) disable iff (reset)
        trap_events.bad_shift |=> trap_flags_reg[BAD_SHIFT_BIT];
    endproperty
    a_shift_set: assert property (p_shift_set) else $error("shift flag missed");

    property p_div_set;
        @(posedge clock) disable iff (reset)
        trap_events.divide_zero |=> trap_flags_reg[DIV_ZERO_BIT];
    endproperty
    a_div_set: assert property (p_div_set) else $error("divide flag missed");

    property p_osc_set;
        @(posedge clock) disable iff (reset)
        trap_events.osc_failure |=> trap_flags_reg[OSC_FAIL_BIT];
    endproperty
    a_osc_set: assert property (p_osc_set) else $error("oscillator flag missed");

    // Timed disable shows in the status bit and holds user interrupts off
    property p_timed_block;
        @(posedge clock) disable iff (reset)
        timed_irq_disable_in |=> global_ctrl_reg[TIMED_DIS_BIT] && !core_ctrl.user_irq_allowed;
    endproperty
    a_timed_block: assert property (p_timed_block) else $error("timed disable ignored");
endmodule : trap_ctrl_regs
`default_nettype wire

// File: verification/trap_and_interrupt_control_regs_bench.sv
// Self-checking bench for the trap and interrupt control registers
`default_nettype none
module trap_and_interrupt_control_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import trap_ctrl_pkg::*;
    // Expected flag bits per event, in event struct order
    localparam logic [15:0] EV_EXP [14] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810,
        16'h0090, 16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002, 16'h0200, 16'h0100,
        16'h0010, 16'h0001};
    logic clock;
    logic reset;
    reg_req_s reg_req;
    logic [15:0] reg_rdata;
    trap_events_s trap_events;
    logic timed_irq_disable_in;
    logic priority_raise;
    logic [3:0] priority_raise_level;
    logic [3:0] ext_irq_pin;
    logic [3:0] ext_irq_edge;
    core_ctrl_s core_ctrl;
    logic math_trap;
    logic acc_overflow_trap;
    int fails;
    int checks_done;

    trap_ctrl_regs dut_u (.clock(clock), .reset(reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .trap_events(trap_events),
        .timed_irq_disable_in(timed_irq_disable_in), .priority_raise(priority_raise),
        .priority_raise_level(priority_raise_level), .ext_irq_pin(ext_irq_pin),
        .ext_irq_edge(ext_irq_edge), .core_ctrl(core_ctrl), .math_trap(math_trap),
        .acc_overflow_trap(acc_overflow_trap));
    trap_source_model partner_u (.clock(clock), .trap_events(trap_events),
        .timed_irq_disable_in(timed_irq_disable_in), .priority_raise(priority_raise),
        .priority_raise_level(priority_raise_level), .ext_irq_pin(ext_irq_pin));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // Write taken and in effect at the second edge; the third edge only adds margin
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge clock);
        reg_req.write <= 1'b0;
        @(posedge clock);
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe is taken
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
        @(posedge clock);
        reg_req.read <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd_chk

    // Combinational trap outputs are judged in the event's own cycle
    task automatic ev_comb(input logic [13:0] ev, input logic [1:0] exp);
        fork
            partner_u.pulse(ev);
            begin
                @(posedge clock);
                #1;
                check(16'({math_trap, acc_overflow_trap}), 16'(exp));
            end
        join
    endtask : ev_comb

    task automatic t_reset();
        rd_chk(4'h0, 16'h0000);
        rd_chk(4'h1, 16'h0000);
        rd_chk(4'h2, 16'h8000);
        rd_chk(4'h3, 16'h0000);
        rd_chk(4'h4, 16'h0000);
        rd_chk(4'h5, 16'h0000);
        rd_chk(4'h9, 16'h0000);
        check(16'(core_ctrl.user_irq_allowed), 16'h0001);
    endtask : t_reset

    // All-ones writes expose the masks; locked priority bits while nesting is off
    task automatic t_masks();
        wr(4'h4, 16'hffff);
        rd_chk(4'h4, 16'h00e0);
        wr(4'h0, 16'hffff);
        rd_chk(4'h0, 16'h8000);
        check(16'(core_ctrl.variable_latency), 16'h0001);
        wr(4'h2, 16'hffff);
        rd_chk(4'h2, 16'ha10f);
        check(16'({core_ctrl.alt_vector_table, core_ctrl.software_trap}), 16'h0003);
        wr(4'h3, 16'hffff);
        rd_chk(4'h3, 16'h0311);
        wr(4'h1, 16'hffff);
        rd_chk(4'h1, 16'hfffe);
        check(16'(core_ctrl.nesting_disabled), 16'h0001);
        wr(4'h4, 16'h0000);
        rd_chk(4'h4, 16'h00e0);
        wr(4'h1, 16'h0000);
        check(16'(core_ctrl.nesting_disabled), 16'h0000);
        wr(4'h4, 16'h0000);
        rd_chk(4'h4, 16'h0000);
        wr(4'h0, 16'h0000);
        check(16'(core_ctrl.variable_latency), 16'h0000);
        wr(4'h2, 16'h8000);
        check(16'({core_ctrl.alt_vector_table, core_ctrl.software_trap}), 16'h0000);
        wr(4'h3, 16'h0000);
    endtask : t_masks

    // Every trap source with enables on, then gating, then set beating a clear
    task automatic t_events();
        wr(4'h1, 16'h0700);
        for (int i = 0; i < 14; i++) begin
            partner_u.pulse(14'h0001 << (13 - i));
            rd_chk(i < 10 ? 4'h1 : 4'h3, EV_EXP[i] | (i < 10 ? 16'h0700 : 16'h0000));
            wr(4'h1, 16'h0700);
            wr(4'h3, 16'h0000);
        end
        ev_comb(14'h2000, 2'b11);
        ev_comb(14'h0200, 2'b10);
        wr(4'h1, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            ev_comb(14'h2000 >> i, 2'b00);
        end
        rd_chk(4'h1, 16'h0000);
        wr(4'h1, 16'h0400);
        partner_u.pulse(14'h1000);
        rd_chk(4'h1, 16'h0400);
        fork
            wr(4'h1, 16'h0000);
            partner_u.pulse(14'h0020);
        join
        rd_chk(4'h1, 16'h0004);
        wr(4'h1, 16'h0000);
    endtask : t_events

    task automatic t_priority();
        partner_u.raise(4'h8);
        #1;
        check(16'(core_ctrl.priority_level), 16'h0008);
        check(16'(core_ctrl.user_irq_allowed), 16'h0000);
        rd_chk(4'h0, 16'h0008);
        rd_chk(4'h4, 16'h0000);
        wr(4'h0, 16'h0000);
        check(16'(core_ctrl.priority_level), 16'h0000);
        check(16'(core_ctrl.user_irq_allowed), 16'h0001);
        partner_u.raise(4'h7);
        rd_chk(4'h0, 16'h0000);
        rd_chk(4'h4, 16'h00e0);
        wr(4'h0, 16'h0008);
        rd_chk(4'h0, 16'h0000);
        partner_u.raise(4'hf);
        rd_chk(4'h0, 16'h0008);
        check(16'(core_ctrl.priority_level), 16'h000f);
        partner_u.raise(4'h0);
    endtask : t_priority

    task automatic t_global();
        wr(4'h2, 16'h0000);
        check(16'(core_ctrl.user_irq_allowed), 16'h0000);
        wr(4'h2, 16'h8000);
        check(16'(core_ctrl.user_irq_allowed), 16'h0001);
        partner_u.timed(1'b1);
        rd_chk(4'h2, 16'hc000);
        check(16'(core_ctrl.user_irq_allowed), 16'h0000);
        partner_u.timed(1'b0);
        rd_chk(4'h2, 16'h8000);
    endtask : t_global

    // Count edge pulses over a window long enough for the synchroniser
    task automatic edge_count(input int i, input logic v, input logic hit);
        int n;
        logic [3:0] other;
        n = 0;
        other = 4'h0;
        partner_u.pin(i, v);
        repeat (8) begin
            @(posedge clock);
            #1;
            n += int'(ext_irq_edge[i]);
            other |= ext_irq_edge & ~(4'h1 << i);
        end
        check(16'(n), hit ? 16'h0001 : 16'h0000);
        check(16'(other), 16'h0000);
    endtask : edge_count

    task automatic t_ext();
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) begin
                wr(4'h2, p == 1 ? 16'h800f : 16'h8000);
                edge_count(i, 1'b1, p == 0);
                edge_count(i, 1'b0, p == 1);
            end
        end
    endtask : t_ext

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Main sequence
    initial begin
        fails = 0;
        checks_done = 0;
        reset = 1'b1;
        reg_req = '0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_masks();
        t_events();
        t_priority();
        t_global();
        t_ext();
        results();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        fails++;
        results();
    end
endmodule : trap_and_interrupt_control_regs_bench
`default_nettype wire

// File: verification/trap_source_model.sv
// Behavioural core and trap sources that sit on the far side of the register block
`default_nettype none
module trap_source_model (
    input wire logic clock,
    output trap_ctrl_pkg::trap_events_s trap_events,
    output logic timed_irq_disable_in,
    output logic priority_raise,
    output logic [3:0] priority_raise_level,
    output logic [3:0] ext_irq_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    import trap_ctrl_pkg::*;

    // Quiet sources until the bench asks for something
    initial begin
        trap_events = '0;
        timed_irq_disable_in = 1'b0;
        priority_raise = 1'b0;
        priority_raise_level = 4'h0;
        ext_irq_pin = 4'h0;
    end

    // One-cycle event pulse launched just after an edge
    task automatic pulse(input logic [13:0] ev);
        @(posedge clock);
        trap_events <= trap_events_s'(ev);
        @(posedge clock);
        trap_events <= '0;
    endtask : pulse

    // Core loads a new priority on exception entry or return
    task automatic raise(input logic [3:0] level);
        @(posedge clock);
        priority_raise <= 1'b1;
        priority_raise_level <= level;
        @(posedge clock);
        priority_raise <= 1'b0;
    endtask : raise

    task automatic timed(input logic v);
        @(posedge clock);
        timed_irq_disable_in <= v;
    endtask : timed

    // Pins are asynchronous to the block; the synchroniser absorbs their phase
    task automatic pin(input int i, input logic v);
        @(posedge clock);
        ext_irq_pin[i] <= v;
    endtask : pin
endmodule : trap_source_model
`default_nettype wire
